// File: abs_regs.svh
`ifndef ABS_REGS_SVH
`define ABS_REGS_SVH

// ****************************************
// Register layout and defaults
// ****************************************
`define ABS_R1_RESET   3'h3
`define ABS_R1_LOW     3'h0
`define ABS_R2_RESET   6'h00
`define ABS_R2_LOW     2'h3
`define ABS_ADDR_TOP   2'h3
`define ABS_BIT_LAST   4'h8

// ****************************************
// Timing
// ****************************************
`define ABS_CLK_NS     4
`define ABS_GLITCH_NS  50
// A pulse of w ns is sampled at most w/period+1 times, so demand one more
`define ABS_GLITCH_CYC ((`ABS_GLITCH_NS / `ABS_CLK_NS) + 2)
// Covers synchroniser plus filter lag of the side just released
`define ABS_RELAY_HOLD 5'h14

`endif

// File: abs_pkg.sv
package abs_pkg;

    typedef enum logic [2:0] {
        st_idle,
        st_addr,
        st_addr_ack,
        st_wr_byte,
        st_wr_ack,
        st_rd_byte,
        st_rd_ack
    } abs_slave_state_type;

    typedef enum logic [1:0] {
        rl_idle,
        rl_from_bp,
        rl_from_card,
        rl_hold
    } abs_relay_type;

endpackage

// File: abs_glitch_filter.sv
`timescale 1ns/1ns
`include "abs_regs.svh"

module abs_glitch_filter
    import abs_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic srst,
    input  wire logic line_raw,
    output logic      line_clean
);

    localparam logic [3:0] GLITCH_LAST = 4'(`ABS_GLITCH_CYC - 1);

    logic       meta_ff;
    logic       sync_ff;
    logic       clean_ff;
    logic [3:0] cnt_ff;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            meta_ff <= 1'b1;
            sync_ff <= 1'b1;
        end else begin
            meta_ff <= line_raw;
            sync_ff <= meta_ff;
        end
    end

    // Short pulses never reach the serial logic
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cnt_ff   <= 4'h0;
            clean_ff <= 1'b1;
        end else if (sync_ff == clean_ff) begin
            cnt_ff <= 4'h0;
        end else if (cnt_ff == GLITCH_LAST) begin
            clean_ff <= sync_ff;
            cnt_ff   <= 4'h0;
        end else begin
            cnt_ff <= cnt_ff + 4'h1;
        end
    end

    assign line_clean = clean_ff;

    property p_glitch;
        @(posedge clk_sys) disable iff (srst)
        $changed(clean_ff) |-> $past(cnt_ff) == GLITCH_LAST;
    endproperty
    a_glitch: assert property (p_glitch)
        else $error("filtered line changed too early");

endmodule // abs_glitch_filter

// File: abs_switch.sv
`timescale 1ns/1ns
`include "abs_regs.svh"


module abs_switch
    import abs_pkg::*;
#(
    parameter bit SINGLE_PIN = 1'b0
)
(
    input  wire logic       clk_sys,
    input  wire logic       srst,
    input  wire logic       register_clear_n,
    input  wire logic [4:0] slave_address,
    input  wire logic       backplane_data_line_in,
    output logic            backplane_data_line_out,
    output logic            backplane_data_line_oe,
    input  wire logic       backplane_clock_line_in,
    output logic            backplane_clock_line_out,
    output logic            backplane_clock_line_oe,
    input  wire logic       card_data_line_in,
    output logic            card_data_line_out,
    output logic            card_data_line_oe,
    input  wire logic       card_clock_line_in,
    output logic            card_clock_line_out,
    output logic            card_clock_line_oe,
    input  wire logic       general_pin_1_in,
    output logic            general_pin_1_out,
    output logic            general_pin_1_oe,
    input  wire logic       general_pin_2_in,
    output logic            general_pin_2_out,
    output logic            general_pin_2_oe,
    output logic            link_connected,
    output logic            card_edge_boost_en,
    output logic            backplane_edge_boost_en
);

    // ****************************************
    // Declarations
    // ****************************************
    abs_slave_state_type state_ff;
    logic [3:0]          bit_cnt_ff;
    logic [7:0]          shift_ff;
    logic                rnw_ff;
    logic                mack_ff;
    logic                drive_low_ff;
    logic [7:0]          pend0_ff;
    logic [7:0]          pend1_ff;
    logic [1:0]          pend_cnt_ff;
    logic [2:0]          r1_ff;
    logic [5:0]          r2_ff;
    logic [6:0]          pin_meta_ff;
    logic [6:0]          pin_sync_ff;
    logic [3:0]          line_f;
    logic                sda_d_ff;
    logic                scl_d_ff;
    logic [1:0]          gp_out_ff;
    logic [1:0]          gp_oe_ff;
    logic [1:0]          card_oe_w;
    logic [1:0]          bp_oe_w;
    logic                sda;
    logic                scl;
    logic                start_det;
    logic                stop_det;
    logic                scl_rise;
    logic                scl_fall;
    logic                wr_done;
    logic                lvl2;
    logic [4:0]          addr_sync;
    logic [7:0]          img1;
    logic [7:0]          img2;
    logic                clr_meta_n_ff;
    logic                clr_n_ff;

    function automatic logic addr_match(input logic [7:0] b,
                                        input logic [4:0] a);
        return (b[7:6] == `ABS_ADDR_TOP) && (b[5:1] == a);
    endfunction

    // ****************************************
    // Input conditioning
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pin_meta_ff <= 7'h00;
            pin_sync_ff <= 7'h00;
        end else begin
            pin_meta_ff <= {slave_address, general_pin_2_in,
                            general_pin_1_in};
            pin_sync_ff <= pin_meta_ff;
        end
    end

    // Card lines filtered too, keeps both sides on equal lag
    genvar k;
    generate
        for (k = 0; k < 4; k++) begin : g_filt
            logic raw;
            assign raw = (k == 0) ? backplane_data_line_in :
                         (k == 1) ? backplane_clock_line_in :
                         (k == 2) ? card_data_line_in :
                                    card_clock_line_in;
            abs_glitch_filter u_filt (
                .clk_sys    (clk_sys),
                .srst       (srst),
                .line_raw   (raw),
                .line_clean (line_f[k])
            );
        end
    endgenerate

    assign sda       = line_f[0];
    assign scl       = line_f[1];
    assign addr_sync = pin_sync_ff[6:2];
    assign lvl2      = SINGLE_PIN ? 1'b0 : pin_sync_ff[1];

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sda_d_ff <= 1'b1;
            scl_d_ff <= 1'b1;
        end else begin
            sda_d_ff <= sda;
            scl_d_ff <= scl;
        end
    end

    assign start_det = scl && scl_d_ff && sda_d_ff && !sda;
    assign stop_det  = scl && scl_d_ff && !sda_d_ff && sda;
    assign scl_rise  = scl && !scl_d_ff;
    assign scl_fall  = !scl && scl_d_ff;
    assign wr_done   = (state_ff == st_wr_byte) && scl_fall &&
                       (bit_cnt_ff == `ABS_BIT_LAST);

    // Read images
    assign img1 = {r1_ff, lvl2, pin_sync_ff[0], `ABS_R1_LOW};
    assign img2 = {r2_ff, `ABS_R2_LOW};

    // ****************************************
    // Serial slave
    // ****************************************
    // Card masters reach this only through the relay below
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_ff     <= st_idle;
            bit_cnt_ff   <= 4'h0;
            shift_ff     <= 8'h00;
            rnw_ff       <= 1'b0;
            mack_ff      <= 1'b0;
            drive_low_ff <= 1'b0;
        end else if (start_det) begin
            state_ff     <= st_addr;
            bit_cnt_ff   <= 4'h0;
            drive_low_ff <= 1'b0;
        end else if (stop_det) begin
            state_ff     <= st_idle;
            drive_low_ff <= 1'b0;
        end else begin
            unique case (state_ff)
                st_idle: begin
                end
                st_addr: begin
                    if (scl_rise && bit_cnt_ff != `ABS_BIT_LAST) begin
                        shift_ff   <= {shift_ff[6:0], sda};
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end else if (scl_fall &&
                                 bit_cnt_ff == `ABS_BIT_LAST) begin
                        if (addr_match(shift_ff, addr_sync)) begin
                            drive_low_ff <= 1'b1;
                            rnw_ff       <= shift_ff[0];
                            state_ff     <= st_addr_ack;
                        end else begin
                            state_ff <= st_idle;
                        end
                    end
                end
                st_addr_ack: begin
                    if (scl_fall && rnw_ff) begin
                        shift_ff     <= img1;
                        drive_low_ff <= !img1[7];
                        bit_cnt_ff   <= 4'h1;
                        state_ff     <= st_rd_byte;
                    end else if (scl_fall) begin
                        drive_low_ff <= 1'b0;
                        bit_cnt_ff   <= 4'h0;
                        state_ff     <= st_wr_byte;
                    end
                end
                st_wr_byte: begin
                    if (scl_rise && bit_cnt_ff != `ABS_BIT_LAST) begin
                        shift_ff   <= {shift_ff[6:0], sda};
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end else if (wr_done) begin
                        drive_low_ff <= 1'b1;
                        state_ff     <= st_wr_ack;
                    end
                end
                st_wr_ack: begin
                    if (scl_fall) begin
                        drive_low_ff <= 1'b0;
                        bit_cnt_ff   <= 4'h0;
                        state_ff     <= st_wr_byte;
                    end
                end
                st_rd_byte: begin
                    if (scl_fall && bit_cnt_ff == `ABS_BIT_LAST) begin
                        drive_low_ff <= 1'b0;
                        mack_ff      <= 1'b0;
                        state_ff     <= st_rd_ack;
                    end else if (scl_fall) begin
                        drive_low_ff <= !shift_ff[6];
                        shift_ff     <= {shift_ff[6:0], 1'b0};
                        bit_cnt_ff   <= bit_cnt_ff + 4'h1;
                    end
                end
                st_rd_ack: begin
                    if (scl_rise) begin
                        mack_ff <= !sda;
                    end else if (scl_fall && mack_ff) begin
                        shift_ff     <= img2;
                        drive_low_ff <= !img2[7];
                        bit_cnt_ff   <= 4'h1;
                        state_ff     <= st_rd_byte;
                    end else if (scl_fall) begin
                        state_ff <= st_idle;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Pending write bytes
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pend0_ff    <= 8'h00;
            pend1_ff    <= 8'h00;
            pend_cnt_ff <= 2'h0;
        end else if (start_det || stop_det) begin
            pend_cnt_ff <= 2'h0;
        end else if (wr_done) begin
            if (pend_cnt_ff == 2'h0) begin
                pend0_ff <= shift_ff;
            end
            if (pend_cnt_ff == 2'h1) begin
                pend1_ff <= shift_ff;
            end
            if (pend_cnt_ff != 2'h3) begin
                pend_cnt_ff <= pend_cnt_ff + 2'h1;
            end
        end
    end

    // ****************************************
    // Control registers
    // ****************************************
    // Clear pin acts without the clock so a card pulled out is safe
    // Release is synchronised so no register leaves clear mid-edge
    always_ff @(posedge clk_sys or negedge register_clear_n) begin
        if (!register_clear_n) begin
            clr_meta_n_ff <= 1'b0;
            clr_n_ff      <= 1'b0;
        end else begin
            clr_meta_n_ff <= 1'b1;
            clr_n_ff      <= clr_meta_n_ff;
        end
    end

    always_ff @(posedge clk_sys or negedge clr_n_ff) begin
        if (!clr_n_ff) begin
            r1_ff <= `ABS_R1_RESET;
            r2_ff <= `ABS_R2_RESET;
        end else if (srst) begin
            r1_ff <= `ABS_R1_RESET;
            r2_ff <= `ABS_R2_RESET;
        end else if (stop_det && pend_cnt_ff != 2'h0) begin
            r1_ff <= pend0_ff[7:5];
            if (pend_cnt_ff != 2'h1) begin
                r2_ff <= pend1_ff[7:2];
            end
        end
    end

    assign link_connected          = r1_ff[2];
    assign card_edge_boost_en      = r2_ff[1];
    assign backplane_edge_boost_en = r2_ff[0];

    // ****************************************
    // General pins
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_pin
            logic off;
            assign off = SINGLE_PIN && (g == 1);
            always_ff @(posedge clk_sys) begin
                if (srst) begin
                    gp_out_ff[g] <= 1'b0;
                    gp_oe_ff[g]  <= 1'b0;
                end else begin
                    gp_out_ff[g] <= r2_ff[2+g] && r1_ff[g];
                    gp_oe_ff[g]  <= !off && !r2_ff[4+g] &&
                                    (r2_ff[2+g] || !r1_ff[g]);
                end
            end
        end
    endgenerate

    assign general_pin_1_out = gp_out_ff[0];
    assign general_pin_1_oe  = gp_oe_ff[0];
    assign general_pin_2_out = gp_out_ff[1];
    assign general_pin_2_oe  = gp_oe_ff[1];

    // ****************************************
    // Line relay
    // ****************************************
    // Direction is latched so our own drive cannot hold itself low
    genvar j;
    generate
        for (j = 0; j < 2; j++) begin : g_relay
            abs_relay_type rl_ff;
            logic [4:0]    hold_ff;
            logic          card_oe_ff;
            logic          bp_oe_ff;
            logic          bp_low;
            logic          card_low;
            assign bp_low   = !line_f[j];
            assign card_low = !line_f[j+2];
            always_ff @(posedge clk_sys) begin
                if (srst || !r1_ff[2]) begin
                    rl_ff   <= rl_idle;
                    hold_ff <= 5'h00;
                end else begin
                    unique case (rl_ff)
                        rl_idle: begin
                            if (bp_low) begin
                                rl_ff <= rl_from_bp;
                            end else if (card_low) begin
                                rl_ff <= rl_from_card;
                            end
                        end
                        rl_from_bp: begin
                            if (!bp_low) begin
                                rl_ff   <= rl_hold;
                                hold_ff <= 5'h00;
                            end
                        end
                        rl_from_card: begin
                            if (!card_low) begin
                                rl_ff   <= rl_hold;
                                hold_ff <= 5'h00;
                            end
                        end
                        rl_hold: begin
                            if (hold_ff == `ABS_RELAY_HOLD) begin
                                rl_ff <= rl_idle;
                            end else begin
                                hold_ff <= hold_ff + 5'h01;
                            end
                        end
                    endcase
                end
            end
            always_ff @(posedge clk_sys) begin
                if (srst) begin
                    card_oe_ff <= 1'b0;
                    bp_oe_ff   <= 1'b0;
                end else begin
                    card_oe_ff <= (rl_ff == rl_from_bp);
                    bp_oe_ff   <= (rl_ff == rl_from_card) ||
                                  ((j == 0) && drive_low_ff);
                end
            end
            assign card_oe_w[j] = card_oe_ff;
            assign bp_oe_w[j]   = bp_oe_ff;
        end
    endgenerate

    // Open-drain lines only ever pull low
    assign backplane_data_line_out  = 1'b0;
    assign backplane_clock_line_out = 1'b0;
    assign card_data_line_out       = 1'b0;
    assign card_clock_line_out      = 1'b0;
    assign backplane_data_line_oe   = bp_oe_w[0];
    assign backplane_clock_line_oe  = bp_oe_w[1];
    assign card_data_line_oe        = card_oe_w[0];
    assign card_clock_line_oe       = card_oe_w[1];

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst || !clr_n_ff);

    sequence s_wr_done;
        (state_ff == st_wr_byte) && scl_fall &&
        (bit_cnt_ff == `ABS_BIT_LAST);
    endsequence
    sequence s_commit;
        stop_det && (pend_cnt_ff != 2'h0);
    endsequence

    property p_commit_r1;
        s_commit |=> {5'h00, r1_ff} == ($past(pend0_ff) >> 5);
    endproperty
    a_commit_r1: assert property (p_commit_r1)
        else $error("first register not committed");

    property p_commit_r2;
        stop_det && pend_cnt_ff[1] |=>
            {r2_ff, 2'h0} == ($past(pend1_ff) & 8'hFC);
    endproperty
    a_commit_r2: assert property (p_commit_r2)
        else $error("second register not committed");

    property p_start_drop;
        start_det |=> pend_cnt_ff == 2'h0 && $stable(r1_ff);
    endproperty
    a_start_drop: assert property (p_start_drop)
        else $error("pending bytes survived a start");

    property p_wr_ack;
        s_wr_done |=> drive_low_ff ##1 backplane_data_line_oe;
    endproperty
    a_wr_ack: assert property (p_wr_ack)
        else $error("data byte not acknowledged");

    property p_no_match;
        state_ff == st_addr && scl_fall && bit_cnt_ff == `ABS_BIT_LAST &&
        !addr_match(shift_ff, addr_sync) |=>
            state_ff == st_idle && !drive_low_ff;
    endproperty
    a_no_match: assert property (p_no_match)
        else $error("foreign address acknowledged");

    property p_rd_first;
        state_ff == st_addr_ack && scl_fall && rnw_ff |=>
            shift_ff[2:0] == `ABS_R1_LOW && shift_ff[7:5] == r1_ff;
    endproperty
    a_rd_first: assert property (p_rd_first)
        else $error("first read byte malformed");

    property p_rd_second;
        state_ff == st_rd_ack && scl_fall && mack_ff |=>
            shift_ff[1:0] == `ABS_R2_LOW && state_ff == st_rd_byte;
    endproperty
    a_rd_second: assert property (p_rd_second)
        else $error("second read byte malformed");

    property p_pin_input;
        r2_ff[4] |=> !general_pin_1_oe;
    endproperty
    a_pin_input: assert property (p_pin_input)
        else $error("input pin driven");

    property p_disc;
        !link_connected [*3] |-> !card_data_line_oe && !card_clock_line_oe;
    endproperty
    a_disc: assert property (p_disc)
        else $error("card driven while disconnected");

    property p_clear;
        @(posedge clk_sys) disable iff (srst)
        !register_clear_n |->
            r1_ff == `ABS_R1_RESET && r2_ff == `ABS_R2_RESET;
    endproperty
    a_clear: assert property (p_clear)
        else $error("registers not at default under clear");

endmodule // abs_switch

// File: abs_i2c_master.sv
`timescale 1ns/1ns
// ******************
// Backplane master
// ******************
module abs_i2c_master (
    input  wire logic clk_sys,
    input  wire logic sda,
    output logic      sda_o,
    output logic      scl_o
);
    localparam int Q = 157; // Quarter bit: 398 kHz
    logic [7:0] res;
    event       res_ev;
    initial begin
        sda_o = 1'h1;
        scl_o = 1'h1;
    end
    task automatic w(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Also a repeated start from a low clock
    task automatic start();
        sda_o <= 1'h1;
        w(Q);
        scl_o <= 1'h1;
        w(Q);
        sda_o <= 1'h0;
        w(Q);
        scl_o <= 1'h0;
        w(Q);
    endtask
    task automatic stop();
        sda_o <= 1'h0;
        w(Q);
        scl_o <= 1'h1;
        w(Q);
        sda_o <= 1'h1;
        w(2 * Q);
    endtask
    // Data moves only while the clock is low
    task automatic bit_x(input logic b, output logic r);
        sda_o <= b;
        w(Q);
        scl_o <= 1'h1;
        w(Q);
        r = sda;
        w(Q);
        scl_o <= 1'h0;
        w(Q);
    endtask
    task automatic byte_op(input logic [7:0] d, input logic mack,
                           input logic rd);
        logic [7:0] q;
        logic       a;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], a);
            q = {q[6:0], a};
        end
        bit_x(mack, a);
        res = rd ? q : {7'h00, a};
        -> res_ev;
    endtask
endmodule // abs_i2c_master

// File: test_addressable_bus_switch_regs.sv
`timescale 1ns/1ns
module test_addressable_bus_switch_regs;
    logic        clk_sys = 1'h0;
    logic        srst = 1'h1;
    logic        register_clear_n = 1'h1;
    logic [4:0]  addr;
    logic [31:0] seed = 32'h5080;
    logic        m_sda, m_scl, bd_oe, bc_oe, cd_oe, cc_oe;
    logic        g1_out, g1_oe, g2_out, g2_oe, link, cbst, bbst;
    logic [7:0]  exp_q[$];
    int          fails = 0;
    int          n_tests = 0;
    wire         bp_sda = m_sda & ~bd_oe;
    wire         bp_scl = m_scl & ~bc_oe;
    wire         g1 = g1_oe ? g1_out : 1'h1; // Pull-up when released
    wire         g2 = g2_oe ? g2_out : 1'h1;
    always #2 clk_sys = ~clk_sys;
    abs_i2c_master m (.clk_sys(clk_sys), .sda(bp_sda), .sda_o(m_sda),
                      .scl_o(m_scl));
    abs_switch dut (.clk_sys(clk_sys), .srst(srst),
        .register_clear_n(register_clear_n), .slave_address(addr),
        .backplane_data_line_in(bp_sda), .backplane_data_line_out(),
        .backplane_data_line_oe(bd_oe), .backplane_clock_line_in(bp_scl),
        .backplane_clock_line_out(), .backplane_clock_line_oe(bc_oe),
        .card_data_line_in(~cd_oe), .card_data_line_out(),
        .card_data_line_oe(cd_oe), .card_clock_line_in(~cc_oe),
        .card_clock_line_out(), .card_clock_line_oe(cc_oe),
        .general_pin_1_in(g1), .general_pin_1_out(g1_out),
        .general_pin_1_oe(g1_oe), .general_pin_2_in(g2),
        .general_pin_2_out(g2_out), .general_pin_2_oe(g2_oe),
        .link_connected(link), .card_edge_boost_en(cbst),
        .backplane_edge_boost_en(bbst));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    always @(m.res_ev) begin
        chk(m.res, exp_q.pop_front());
    end
    task automatic wr(input logic [7:0] d);
        exp_q.push_back(8'h00);
        m.byte_op(d, 1'h1, 1'h0);
    endtask
    task automatic rd(input logic [7:0] e, input logic mack);
        exp_q.push_back(e);
        m.byte_op(8'hFF, mack, 1'h1);
    endtask
    task automatic adr(input logic r);
        m.start();
        wr({2'h3, addr, r});
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (110000) @(posedge clk_sys);
        fails++;
        final_report();
    end
    initial begin
        seed = lfsr(seed);
        addr <= seed[15:11];
        repeat (16) @(posedge clk_sys);
        srst <= 1'h0;
        repeat (30) @(posedge clk_sys);
        m.start();
        exp_q.push_back(8'h01);
        m.byte_op({2'h2, addr, 1'h0}, 1'h1, 1'h0);
        m.stop();
        $display("test foreign address done");
        adr(0);
        wr(8'h20);
        wr(8'h10);
        m.stop();
        chk({4'h0, g1_oe, g1_out, g2_oe, g2_out}, 8'h0E);
        adr(0);
        wr(8'h80);
        adr(1);
        rd(8'h28, 1'h0);
        rd(8'h13, 1'h1);
        m.stop();
        $display("test pins and abort done");
        seed = lfsr(seed);
        adr(0);
        wr(8'h9F);
        wr(8'hCC);
        wr(seed[7:0]);
        wr(seed[15:8]);
        m.stop();
        chk({7'h00, link}, 8'h01);
        chk({6'h00, cbst, bbst}, 8'h03);
        chk({6'h00, g1_oe, g2_oe}, 8'h00);
        chk({6'h00, cd_oe, cc_oe}, 8'h00);
        m.start();
        chk({6'h00, cd_oe, cc_oe}, 8'h03);
        m.stop();
        $display("test write word done");
        register_clear_n <= 1'h0;
        repeat (4) @(posedge clk_sys);
        chk({7'h00, link}, 8'h00);
        register_clear_n <= 1'h1;
        repeat (4) @(posedge clk_sys);
        adr(1);
        rd(8'h78, 1'h0);
        rd(8'h03, 1'h1);
        m.stop();
        $display("test clear done");
        final_report();
    end
endmodule // test_addressable_bus_switch_regs
